/* design/mssu_top.sv */
// Chosen here: the APB slave port.
`timescale 1ns/10ps
`include "mssu_cfg.svh"
// safety and status unit: parity control, serial loopback, status events
module mssu_top (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [17:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic [3:0]          pstrb,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                parity_error,
  input  wire logic                crc_done,
  input  wire logic                flash_done,
  input  wire logic                parity_control_guard,
  input  wire mssu_pkg::mssu_lane_t uart_txd,
  input  wire mssu_pkg::mssu_lane_t csp_txd,
  input  wire mssu_pkg::mssu_lane_t uart_rxd_pin,
  input  wire mssu_pkg::mssu_lane_t csp_rxd_pin,
  output mssu_pkg::mssu_lane_t      uart_rxd_unit,
  output mssu_pkg::mssu_lane_t      csp_rxd_unit,
  output mssu_pkg::mssu_lane_t      loopback_enable,
  output logic                     parity_reset_req,
  output logic                     reset_cause_parity,
  output logic                     status_irq_req,
  output logic                     irq
);

  // register state
  logic                  par_en_q;
  logic                  par_flag_q;
  logic                  par_flag_d;
  logic [15:0]           loop_q;
  mssu_pkg::mssu_evt_t   evt_en_q;
  mssu_pkg::mssu_evt_t   evt_flags;
  mssu_pkg::mssu_evt_t   evt_in;
  mssu_pkg::mssu_evt_t   evt_clr;
  mssu_pkg::mssu_evt_t   evt_req;
  mssu_pkg::mssu_evt_t   irq_stat_q;
  mssu_pkg::mssu_evt_t   irq_stat_d;
  mssu_pkg::mssu_evt_t   irq_mask_q;
  logic                  req_d;
  logic                  par_rst_d;

  // bus decode
  mssu_pkg::mssu_idx_t   idx;
  logic                  access;
  logic                  wr;
  logic                  rd;
  logic                  hit_en;
  logic                  hit_flags;
  logic                  hit_clear;
  logic                  hit_par;
  logic                  hit_loop;
  logic                  hit_istat;
  logic                  hit_imask;
  logic                  mapped;
  logic                  wr_lo;
  logic                  wr_hi;
  logic                  wr_par;
  logic                  rereq_wr;
  logic [15:0]           loop_wmask;

  // zero-wait slave: every access completes in its first access cycle
  assign idx     = paddr[17:2];
  assign access  = psel & penable;
  assign wr      = access & pwrite;
  assign rd      = access & ~pwrite;
  assign wr_lo   = wr & pstrb[0];
  assign wr_hi   = wr & pstrb[1];
  assign pready  = 1'b1;

  assign hit_en    = (idx == `MSSU_IDX_EVT_ENABLE);
  assign hit_flags = (idx == `MSSU_IDX_EVT_FLAGS);
  assign hit_clear = (idx == `MSSU_IDX_EVT_CLEAR);
  assign hit_par   = (idx == `MSSU_IDX_PAR_CTRL);
  assign hit_loop  = (idx == `MSSU_IDX_LOOPBACK);
  assign hit_istat = (idx == `MSSU_IDX_IRQ_STAT);
  assign hit_imask = (idx == `MSSU_IDX_IRQ_MASK);
  assign mapped    = hit_en | hit_flags | hit_clear | hit_par | hit_loop
                   | hit_istat | hit_imask;
  // unmapped words answer with an error and change nothing
  assign pslverr   = access & ~mapped;

  // guard bit blocks software writes but hardware still sets the flag
  assign wr_par    = wr_lo & hit_par & ~parity_control_guard;

  // read mux; the clear register reads as zero whatever was written
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      if (hit_en) begin
        prdata[2:0] = evt_en_q;
      end else if (hit_flags) begin
        prdata[2:0] = evt_flags;
      end else if (hit_par) begin
        prdata[`MSSU_PAR_FLAG_BIT] = par_flag_q;
        prdata[`MSSU_PAR_EN_BIT]   = par_en_q;
      end else if (hit_loop) begin
        prdata[15:0] = loop_q;
      end else if (hit_istat) begin
        prdata[2:0] = irq_stat_q;
      end else if (hit_imask) begin
        prdata[2:0] = irq_mask_q;
      end else begin
        prdata = 32'h0000_0000;
      end
    end
  end

  // parity flag: set wins over a write-one clear
  assign par_flag_d = parity_error
                    | (par_flag_q & ~(wr_par & pwdata[`MSSU_PAR_FLAG_BIT]));
  // reset request only while the reset function is enabled
  assign par_rst_d  = parity_error & par_en_q;

  // parity control register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      par_en_q   <= 1'b0;
      par_flag_q <= 1'b0;
    end else begin
      par_flag_q <= par_flag_d;
      if (wr_par) begin
        par_en_q <= pwdata[`MSSU_PAR_EN_BIT];
      end
    end
  end

  // reset request and cause strobe to the reset controller
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      parity_reset_req   <= 1'b0;
      reset_cause_parity <= 1'b0;
    end else begin
      parity_reset_req   <= par_rst_d;
      reset_cause_parity <= par_rst_d;
    end
  end

  // reserved bits outside the mask stay zero whatever software writes
  assign loop_wmask = `MSSU_LOOP_WMASK;

  // loopback test register, byte-lane writable; only bits 5..0 act
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loop_q <= `MSSU_LOOP_RESET;
    end else begin
      if (wr_lo && hit_loop) begin
        loop_q[7:0] <= pwdata[7:0] & loop_wmask[7:0];
      end
      if (wr_hi && hit_loop) begin
        loop_q[15:8] <= pwdata[15:8] & loop_wmask[15:8];
      end
    end
  end
  assign loopback_enable = loop_q[5:0];

  // one receive lane per serial unit
  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : g_lane
      mssu_loop_lane mssu_loop_lane_inst (
        .pclk          (pclk),
        .presetn       (presetn),
        .lb_en         (loop_q[g]),
        .uart_txd      (uart_txd[g]),
        .csp_txd       (csp_txd[g]),
        .uart_rxd_pin  (uart_rxd_pin[g]),
        .csp_rxd_pin   (csp_rxd_pin[g]),
        .uart_rxd_unit (uart_rxd_unit[g]),
        .csp_rxd_unit  (csp_rxd_unit[g])
      );
    end
  endgenerate

  // event enable register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_en_q <= `MSSU_EVT_RESET;
    end else if (wr_lo && hit_en) begin
      evt_en_q <= pwdata[2:0];
    end
  end

  // event sources and write-one clears; byte or word writes both work
  assign evt_in[`MSSU_EVT_PARITY] = parity_error;
  assign evt_in[`MSSU_EVT_CRC]    = crc_done;
  assign evt_in[`MSSU_EVT_FLASH]  = flash_done;
  assign evt_clr  = (wr_lo && hit_clear) ? pwdata[2:0] : 3'h0;
  assign rereq_wr = wr_hi & hit_clear & pwdata[`MSSU_REREQ_BIT];

  generate
    for (g = 0; g < 3; g++) begin : g_evt
      mssu_event_cell mssu_event_cell_inst (
        .pclk     (pclk),
        .presetn  (presetn),
        .event_in (evt_in[g]),
        .clear_in (evt_clr[g]),
        .enable   (evt_en_q[g]),
        .flag_q   (evt_flags[g]),
        .req      (evt_req[g])
      );
    end
  endgenerate

  // merged request: new enabled flag, or re-request with enabled flags left
  assign req_d = (|evt_req) | (rereq_wr & |(evt_flags & evt_en_q));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_irq_req <= 1'b0;
    end else begin
      status_irq_req <= req_d;
    end
  end

  // cpu interrupt: sticky, cleared by reading, set wins over the read
  assign irq_stat_d = evt_in | (irq_stat_q & ~{3{rd & hit_istat}});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= `MSSU_EVT_RESET;
      irq_mask_q <= `MSSU_EVT_RESET;
    end else begin
      irq_stat_q <= irq_stat_d;
      if (wr_lo && hit_imask) begin
        irq_mask_q <= pwdata[2:0];
      end
    end
  end
  // level output, low-latency path from six flops
  assign irq = |(irq_stat_q & irq_mask_q);

  // sequences for the multi-step checks
  sequence s_rereq_pending;
    rereq_wr && (|(evt_flags & evt_en_q));
  endsequence

  sequence s_quiet;
    !(|evt_req) && !rereq_wr;
  endsequence

  a_par_reset_fire: assert property (@(posedge pclk) disable iff (!presetn)
    (parity_error && par_en_q) |=> (parity_reset_req && reset_cause_parity))
    else $error("enabled parity error gave no reset request");

  a_par_reset_off: assert property (@(posedge pclk) disable iff (!presetn)
    !(parity_error && par_en_q) |=> !parity_reset_req)
    else $error("reset request without enabled parity error");

  a_par_flag_set: assert property (@(posedge pclk) disable iff (!presetn)
    parity_error |=> par_flag_q)
    else $error("parity flag not set");

  a_par_guard_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_lo && hit_par && parity_control_guard) |=> $stable(par_en_q))
    else $error("guarded parity control changed");

  a_clear_reads_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit_clear) |-> prdata == 32'h0000_0000)
    else $error("clear register read nonzero");

  a_flag_clear_write: assert property (@(posedge pclk) disable iff (!presetn)
    (evt_clr[`MSSU_EVT_CRC] && !crc_done) |=> !evt_flags[`MSSU_EVT_CRC])
    else $error("crc flag not cleared by write one");

  a_rereq_issue: assert property (@(posedge pclk) disable iff (!presetn)
    s_rereq_pending |=> status_irq_req)
    else $error("re-request write gave no request");

  a_req_on_set: assert property (@(posedge pclk) disable iff (!presetn)
    (flash_done && !evt_flags[`MSSU_EVT_FLASH] && evt_en_q[`MSSU_EVT_FLASH])
      |=> status_irq_req)
    else $error("new enabled flash event gave no request");

  a_req_quiet: assert property (@(posedge pclk) disable iff (!presetn)
    s_quiet |=> !status_irq_req)
    else $error("spurious status request");

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (parity_error && irq_mask_q[`MSSU_EVT_PARITY] && !(wr_lo && hit_imask))
      |=> irq)
    else $error("masked-in event did not raise irq");

  // parity flag clear: a software clear with no fresh error in the same cycle
  sequence s_par_clear;
    wr_par && pwdata[`MSSU_PAR_FLAG_BIT] && !parity_error;
  endsequence

  a_par_flag_clear: assert property (@(posedge pclk) disable iff (!presetn)
    s_par_clear |=> !par_flag_q)
    else $error("parity flag not cleared by write one");

  a_par_flag_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (par_flag_q && !(wr_par && pwdata[`MSSU_PAR_FLAG_BIT])) |=> par_flag_q)
    else $error("parity flag dropped without a clear");

  a_par_en_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_par |=> par_en_q == $past(pwdata[`MSSU_PAR_EN_BIT]))
    else $error("parity reset enable not written");

  a_par_cause_pair: assert property (@(posedge pclk) disable iff (!presetn)
    parity_reset_req |-> reset_cause_parity)
    else $error("reset request without its cause strobe");

  a_loop_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_lo && hit_loop) |=> loopback_enable == $past(pwdata[5:0]))
    else $error("loopback enables not written");

  a_loop_reserved: assert property (@(posedge pclk) disable iff (!presetn)
    (loop_q & ~loop_wmask) == 16'h0000)
    else $error("reserved loopback bit set");

  a_flags_set: assert property (@(posedge pclk) disable iff (!presetn)
    (|evt_in) |=> ((evt_flags & $past(evt_in)) == $past(evt_in)))
    else $error("event flag not set");

  a_flag_zero_write: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_lo && hit_clear && !pwdata[`MSSU_EVT_PARITY] && evt_flags[`MSSU_EVT_PARITY])
      |=> evt_flags[`MSSU_EVT_PARITY])
    else $error("write of zero cleared the parity flag");

  a_flash_disabled: assert property (@(posedge pclk) disable iff (!presetn)
    (flash_done && !evt_en_q[`MSSU_EVT_FLASH] && !crc_done && !parity_error && !rereq_wr)
      |=> !status_irq_req)
    else $error("disabled flash event raised a request");

  a_rereq_empty: assert property (@(posedge pclk) disable iff (!presetn)
    (rereq_wr && !(|(evt_flags & evt_en_q)) && !(|evt_req)) |=> !status_irq_req)
    else $error("re-request with nothing pending");

  a_irq_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (rd && hit_istat && !(|evt_in)) |=> irq_stat_q == 3'h0)
    else $error("irq status not cleared by read");

  a_bad_write_inert: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && !mapped) |=> ($stable(loop_q) && $stable(evt_en_q) && $stable(irq_mask_q)))
    else $error("unmapped write changed a register");

endmodule : mssu_top

/* common/mssu_cfg.svh */
`ifndef MSSU_CFG_SVH
`define MSSU_CFG_SVH

// register indices; byte address is four times the index
`define MSSU_IDX_EVT_ENABLE 16'hf050
`define MSSU_IDX_EVT_FLAGS  16'hf052
`define MSSU_IDX_EVT_CLEAR  16'hf054
`define MSSU_IDX_PAR_CTRL   16'hf0bc
`define MSSU_IDX_LOOPBACK   16'hf0be
`define MSSU_IDX_IRQ_STAT   16'hf060
`define MSSU_IDX_IRQ_MASK   16'hf062

// field positions
`define MSSU_PAR_EN_BIT     0
`define MSSU_PAR_FLAG_BIT   7
`define MSSU_REREQ_BIT      15
`define MSSU_EVT_PARITY     0
`define MSSU_EVT_CRC        1
`define MSSU_EVT_FLASH      2

// writable bit masks and reset values
`define MSSU_LOOP_WMASK     16'h113f
`define MSSU_EVT_RESET      3'h0
`define MSSU_LOOP_RESET     16'h0000
`define MSSU_BYTE_RESET     8'h00

`endif

/* common/mssu_pkg.sv */
package mssu_pkg;

  // one bit per status event: flash, crc, parity
  typedef logic [2:0]  mssu_evt_t;
  // one bit per serial communication unit
  typedef logic [5:0]  mssu_lane_t;
  // register word index
  typedef logic [15:0] mssu_idx_t;

endpackage : mssu_pkg

/* design/mssu_event_cell.sv */
`timescale 1ns/10ps
// one sticky event flag with its request qualifier
module mssu_event_cell (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic event_in,
  input  wire logic clear_in,
  input  wire logic enable,
  output logic      flag_q,
  output logic      req
);

  logic flag_d;

  // set wins over a clear in the same cycle so no event is lost
  assign flag_d = event_in | (flag_q & ~clear_in);
  // a recurring event on a standing flag stays silent unless a clear comes in the same cycle
  assign req    = event_in & enable & (~flag_q | clear_in);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_q <= 1'b0;
    end else begin
      flag_q <= flag_d;
    end
  end

  a_cell_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    event_in |=> flag_q)
    else $error("event flag not set after event");

  a_cell_no_repeat: assert property (@(posedge pclk) disable iff (!presetn)
    (flag_q && !clear_in) |-> !req)
    else $error("request issued on a standing flag");

endmodule : mssu_event_cell

/* design/mssu_loop_lane.sv */
`timescale 1ns/10ps
// receive path of one serial unit: synchronised pin or internal loopback
module mssu_loop_lane (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic lb_en,
  input  wire logic uart_txd,
  input  wire logic csp_txd,
  input  wire logic uart_rxd_pin,
  input  wire logic csp_rxd_pin,
  output logic      uart_rxd_unit,
  output logic      csp_rxd_unit
);

  logic [1:0] uart_sync_q;
  logic [1:0] csp_sync_q;
  logic       uart_rx_d;
  logic       csp_rx_d;

  // loopback takes transmit data directly, so no port setup is needed
  assign uart_rx_d = lb_en ? uart_txd : uart_sync_q[1];
  assign csp_rx_d  = lb_en ? csp_txd : csp_sync_q[1];

  // pins come from outside the clock domain: two flops before any use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uart_sync_q   <= 2'h0;
      csp_sync_q    <= 2'h0;
      uart_rxd_unit <= 1'b0;
      csp_rxd_unit  <= 1'b0;
    end else begin
      uart_sync_q   <= {uart_sync_q[0], uart_rxd_pin};
      csp_sync_q    <= {csp_sync_q[0], csp_rxd_pin};
      uart_rxd_unit <= uart_rx_d;
      csp_rxd_unit  <= csp_rx_d;
    end
  end

  a_loop_uart_route: assert property (@(posedge pclk) disable iff (!presetn)
    $past(lb_en) |-> uart_rxd_unit == $past(uart_txd))
    else $error("uart loopback data not routed");

  a_loop_csp_route: assert property (@(posedge pclk) disable iff (!presetn)
    $past(lb_en) |-> csp_rxd_unit == $past(csp_txd))
    else $error("clocked serial loopback data not routed");

endmodule : mssu_loop_lane

/* dv/mssu_top_tb.sv */
`timescale 1ns/10ps
`include "mssu_cfg.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: got %h expected %h", $time, (a), (b)); end end
// bench for the safety and status unit; reads are checked by a monitor from a queue
module mssu_top_tb;
  logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [17:0]          paddr;
  logic [31:0]          pwdata, prdata, w;
  logic [3:0]           pstrb;
  logic                 par_e, crc_e, fl_e, guard, rst_req, cause, sreq, irq;
  mssu_pkg::mssu_lane_t utx, stx, upin, spin, urx, srx, lben;
  logic [32:0]          exp_q[$], msk_q[$], e, m;
  int                   n_errors, tests_run, n_req, n_rst, cyc, r0;

  mssu_top mssu_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .parity_error(par_e), .crc_done(crc_e),
    .flash_done(fl_e), .parity_control_guard(guard), .uart_txd(utx), .csp_txd(stx),
    .uart_rxd_pin(upin), .csp_rxd_pin(spin), .uart_rxd_unit(urx), .csp_rxd_unit(srx),
    .loopback_enable(lben), .parity_reset_req(rst_req), .reset_cause_parity(cause),
    .status_irq_req(sreq), .irq(irq));

  // clock at 4 ns period
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : wrap_up

  // one apb transfer; request held until pready is seen high at a rising edge
  task automatic apb(input mssu_pkg::mssu_idx_t idx, input logic we,
                     input logic [31:0] wd, input logic [3:0] st);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= we; paddr <= {idx, 2'b00};
    pwdata <= wd; pstrb <= st;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  task automatic wr(input mssu_pkg::mssu_idx_t idx, input logic [31:0] d, input logic [3:0] s);
    apb(idx, 1'b1, d, s);
  endtask : wr

  // read with expected {pslverr, prdata} noted for the monitor
  task automatic rd(input mssu_pkg::mssu_idx_t idx, input logic [32:0] x,
                    input logic [32:0] k = {33{1'b1}});
    exp_q.push_back(x);
    msk_q.push_back(k);
    apb(idx, 1'b0, 32'h0, 4'h0);
  endtask : rd

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  // one-cycle event pulse: 0 parity, 1 crc, 2 flash; parity errors are deliberate only
  task automatic ev(input int i);
    @(posedge pclk);
    par_e <= (i == 0); crc_e <= (i == 1); fl_e <= (i == 2);
    @(posedge pclk);
    {par_e, crc_e, fl_e} <= 3'h0;
    idle(2);
  endtask : ev

  // read data taken at the rising edge that completes the access, as a master does
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        e = exp_q.pop_front();
        m = msk_q.pop_front();
        `CHK({pslverr, prdata} & m, e & m)
      end
    end
  end

  // request pulses are counted mid-cycle, where they stand settled
  always @(negedge pclk) begin
    if (sreq === 1'b1) n_req++;
    if (rst_req === 1'b1) n_rst++;
    if (rst_req || cause) `CHK(cause, rst_req)
  end

  // hang guard well above the expected run length
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      n_errors++;
      wrap_up();
    end
  end

  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 18'h0;
    pwdata = 32'h0; pstrb = 4'h0; par_e = 1'b0; crc_e = 1'b0; fl_e = 1'b0; guard = 1'b0;
    utx = 6'h00; stx = 6'h00; upin = 6'h00; spin = 6'h00;
    void'($urandom(7));
    idle(4);
    presetn <= 1'b1;
    // reset values and the unmapped slot
    rd(`MSSU_IDX_EVT_ENABLE, 33'h0);
    rd(`MSSU_IDX_EVT_FLAGS, 33'h0);
    rd(`MSSU_IDX_EVT_CLEAR, 33'h0);
    rd(`MSSU_IDX_PAR_CTRL, 33'h0);
    rd(`MSSU_IDX_LOOPBACK, 33'h0);
    rd(`MSSU_IDX_IRQ_STAT, 33'h0);
    rd(`MSSU_IDX_IRQ_MASK, 33'h0);
    rd(16'h0123, 33'h1_0000_0000, 33'h1_0000_0000);
    wr(16'h0123, 32'hffff_ffff, 4'hf);
    rd(`MSSU_IDX_EVT_ENABLE, 33'h0);
    $display("test reset_values done");
    // random loopback settings; enabled lanes echo txd, others show the pins
    repeat (4) begin
      w = $urandom;
      wr(`MSSU_IDX_LOOPBACK, w, 4'h3);
      rd(`MSSU_IDX_LOOPBACK, {17'h0, w[15:0] & `MSSU_LOOP_WMASK});
      @(posedge pclk);
      {utx, stx, upin, spin} <= 24'($urandom);
      idle(5);
      @(negedge pclk);
      `CHK(lben, w[5:0])
      `CHK(urx, (w[5:0] & utx) | (~w[5:0] & upin))
      `CHK(srx, (w[5:0] & stx) | (~w[5:0] & spin))
    end
    $display("test loopback done");
    // each event: request, no repeat while set, re-request, clears
    wr(`MSSU_IDX_EVT_ENABLE, 32'h7, 4'h1);
    for (int i = 0; i < 3; i++) begin
      r0 = n_req;
      ev(i);
      `CHK(n_req, r0 + 1)
      rd(`MSSU_IDX_EVT_FLAGS, 33'(1 << i));
      ev(i);
      `CHK(n_req, r0 + 1)
      wr(`MSSU_IDX_EVT_CLEAR, 32'h0, 4'h3);
      rd(`MSSU_IDX_EVT_FLAGS, 33'(1 << i));
      wr(`MSSU_IDX_EVT_CLEAR, 32'h8000, 4'h2);
      idle(2);
      `CHK(n_req, r0 + 2)
      wr(`MSSU_IDX_EVT_CLEAR, 32'(1 << i), 4'h1);
      rd(`MSSU_IDX_EVT_FLAGS, 33'h0);
      rd(`MSSU_IDX_EVT_CLEAR, 33'h0);
      @(negedge pclk);
      `CHK(irq, 1'b0)
    end
    // disabled event still flags but raises nothing, re-request included
    wr(`MSSU_IDX_EVT_ENABLE, 32'h3, 4'h1);
    r0 = n_req;
    ev(2);
    wr(`MSSU_IDX_EVT_CLEAR, 32'h8000, 4'h2);
    idle(2);
    `CHK(n_req, r0)
    rd(`MSSU_IDX_EVT_FLAGS, 33'h4);
    $display("test events done");
    // sticky irq status cleared by reading; level irq follows mask
    rd(`MSSU_IDX_IRQ_STAT, 33'h7);
    rd(`MSSU_IDX_IRQ_STAT, 33'h0);
    wr(`MSSU_IDX_IRQ_MASK, 32'h2, 4'h1);
    ev(1);
    @(negedge pclk);
    `CHK(irq, 1'b1)
    ev(0);
    rd(`MSSU_IDX_IRQ_STAT, 33'h3);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    $display("test irq done");
    // parity flag, write-one clear, reset request, write guard
    rd(`MSSU_IDX_PAR_CTRL, 33'h80);
    wr(`MSSU_IDX_PAR_CTRL, 32'h80, 4'h1);
    rd(`MSSU_IDX_PAR_CTRL, 33'h0);
    r0 = n_rst;
    ev(0);
    `CHK(n_rst, r0)
    wr(`MSSU_IDX_PAR_CTRL, 32'h01, 4'h1);
    ev(0);
    `CHK(n_rst, r0 + 1)
    wr(`MSSU_IDX_PAR_CTRL, 32'h01, 4'h1);
    rd(`MSSU_IDX_PAR_CTRL, 33'h81);
    guard <= 1'b1;
    wr(`MSSU_IDX_PAR_CTRL, 32'h80, 4'h1);
    rd(`MSSU_IDX_PAR_CTRL, 33'h81);
    guard <= 1'b0;
    wr(`MSSU_IDX_PAR_CTRL, 32'h80, 4'h1);
    rd(`MSSU_IDX_PAR_CTRL, 33'h0);
    $display("test parity done");
    idle(2);
    `CHK(exp_q.size(), 0)
    wrap_up();
  end
endmodule : mssu_top_tb
